/* File: logic/bofs_params.svh */
// Timing and counter-width constants for the output fault supervisor
`ifndef BOFS_PARAMS_SVH
`define BOFS_PARAMS_SVH
`define BOFS_CLK_MHZ 125
`define BOFS_OV_FILT_NS 2000
`define BOFS_UV_FILT_NS 2000
`define BOFS_OC_FILT_NS 10000
`define BOFS_OV_CYC ((`BOFS_OV_FILT_NS * `BOFS_CLK_MHZ + 999) / 1000)
`define BOFS_UV_CYC ((`BOFS_UV_FILT_NS * `BOFS_CLK_MHZ + 999) / 1000)
`define BOFS_OC_CYC ((`BOFS_OC_FILT_NS * `BOFS_CLK_MHZ + 999) / 1000)
`define BOFS_CNT_W 11
`endif

/* File: logic/bofs_pkg.sv */
// Types for the output fault supervisor
package bofs_pkg;
    typedef enum logic [1:0] {
        BOFS_PD_NONE = 2'h0,
        BOFS_PD_95 = 2'h1,
        BOFS_PD_60 = 2'h2,
        BOFS_PD_30 = 2'h3
    } bofs_pd_t;
    typedef enum logic [1:0] {
        BOFS_ST_RUN = 2'h0,
        BOFS_ST_OV = 2'h1,
        BOFS_ST_UV = 2'h2,
        BOFS_ST_OC = 2'h3
    } bofs_state_t;
endpackage

/* File: logic/bofs_filt_if.sv */
// Deglitch filter connection: raw condition in, qualified level out
`timescale 1ns/1ps
`default_nettype none
interface bofs_filt_if;
    logic raw;
    logic qual;
    modport filt (input raw, output qual);
    modport user (output raw, input qual);
endinterface
`default_nettype wire

/* File: logic/bofs_deglitch.sv */
// Continuous-time qualifier for one comparator indication
`timescale 1ns/1ps
`default_nettype none
module bofs_deglitch import bofs_pkg::*; #(
    parameter int CYCLES = 250,
    parameter int W = 11
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Condition
    bofs_filt_if.filt f
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic qual;
    } bofs_dg_t;
    localparam logic [W-1:0] LAST = W'(CYCLES);
    bofs_dg_t s_reg, s_next;
    always_comb begin
        s_next = s_reg;
        if (!f.raw) begin
            // Any break restarts the count
            s_next.cnt = '0;
            s_next.qual = 1'b0;
        end else if (s_reg.cnt != LAST) begin
            s_next.cnt = s_reg.cnt + W'(1);
        end else begin
            // Strictly longer than the filter time
            s_next.qual = 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
    assign f.qual = s_reg.qual;
    property p_restart;
        @(posedge clk) disable iff (!rst_n) !f.raw |=> !f.qual && s_reg.cnt == '0;
    endproperty
    a_restart: assert property (p_restart) else $error("filter did not restart");
endmodule
`default_nettype wire

/* File: logic/bofs_top.sv */
// Output fault supervisor: deglitch, latch, pull-down code, discharge drive
//
// What this block does
// - Overvoltage fault only after rising-OV indication holds beyond 2 us.
// - Overvoltage fault latches converter off, pull-down code 60 ohm.
// - Overvoltage latch held until enable low or supply reset.
// - During OV latch, low-side on when rising-OV holds beyond 2 us.
// - During OV latch, low-side off when below falling-OV beyond 2 us.
// - Undervoltage fault only after UV indication holds beyond 2 us.
// - Undervoltage fault latches converter off, pull-down code 95 ohm.
// - Undervoltage latch held until enable low or supply reset.
// - Soft-start also shows the 95 ohm pull-down code.
// - Overcurrent beyond 10 us latches off with 30 ohm code.
`timescale 1ns/1ps
`default_nettype none
`include "bofs_params.svh"
module bofs_top import bofs_pkg::*; #(
    parameter int OV_CYC = `BOFS_OV_CYC,
    parameter int UV_CYC = `BOFS_UV_CYC,
    parameter int OC_CYC = `BOFS_OC_CYC,
    parameter int CNT_W = `BOFS_CNT_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Comparators, high while condition true
    input wire logic fb_above_ov_rise,
    input wire logic fb_below_ov_fall,
    input wire logic fb_below_uv,
    input wire logic current_limit_sense,
    // Supply and enable, high while below falling thresholds; soft-start flag
    input wire logic enable_low,
    input wire logic supply_por,
    input wire logic soft_start,
    // Drivers and pad
    output logic converter_off,
    output logic low_side_drive,
    output logic overvoltage_fault,
    output logic undervoltage_fault,
    output logic overcurrent_fault,
    output bofs_pd_t output_ok_flag
);
    typedef struct packed {
        bofs_state_t st;
        logic ls;
        bofs_pd_t pd;
    } bofs_s_t;
    bofs_s_t s_reg, s_next;
    bofs_filt_if ovr_if();
    bofs_filt_if ovf_if();
    bofs_filt_if uv_if();
    bofs_filt_if oc_if();
    logic clr;
    assign clr = enable_low | supply_por;
    // Filters are parked while cleared so a fresh enable starts clean
    assign ovr_if.raw = fb_above_ov_rise & !clr;
    assign ovf_if.raw = fb_below_ov_fall & !clr;
    assign uv_if.raw = fb_below_uv & !clr;
    assign oc_if.raw = current_limit_sense & !clr;
    bofs_deglitch #(.CYCLES(OV_CYC), .W(CNT_W)) u_ovr (.clk(clk), .rst_n(rst_n), .f(ovr_if));
    bofs_deglitch #(.CYCLES(OV_CYC), .W(CNT_W)) u_ovf (.clk(clk), .rst_n(rst_n), .f(ovf_if));
    bofs_deglitch #(.CYCLES(UV_CYC), .W(CNT_W)) u_uv (.clk(clk), .rst_n(rst_n), .f(uv_if));
    bofs_deglitch #(.CYCLES(OC_CYC), .W(CNT_W)) u_oc (.clk(clk), .rst_n(rst_n), .f(oc_if));
    always_comb begin
        s_next = s_reg;
        if (clr) begin
            s_next.st = BOFS_ST_RUN;
            s_next.ls = 1'b0;
            s_next.pd = BOFS_PD_NONE;
        end else begin
            case (s_reg.st)
                BOFS_ST_RUN: begin
                    // OV first: discharging matters most for the load
                    if (ovr_if.qual) begin
                        s_next.st = BOFS_ST_OV;
                        s_next.pd = BOFS_PD_60;
                        s_next.ls = 1'b1;
                    end else if (oc_if.qual) begin
                        s_next.st = BOFS_ST_OC;
                        s_next.pd = BOFS_PD_30;
                    end else if (uv_if.qual) begin
                        s_next.st = BOFS_ST_UV;
                        s_next.pd = BOFS_PD_95;
                    end else begin
                        s_next.pd = soft_start ? BOFS_PD_95 : BOFS_PD_NONE;
                    end
                end
                BOFS_ST_OV: begin
                    if (ovr_if.qual) begin
                        s_next.ls = 1'b1;
                    end else if (ovf_if.qual) begin
                        s_next.ls = 1'b0;
                    end
                end
                default: begin
                    // Code frozen; later detections have no effect
                    s_next.ls = 1'b0;
                end
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
    assign converter_off = s_reg.st != BOFS_ST_RUN;
    assign low_side_drive = s_reg.ls;
    assign overvoltage_fault = s_reg.st == BOFS_ST_OV;
    assign undervoltage_fault = s_reg.st == BOFS_ST_UV;
    assign overcurrent_fault = s_reg.st == BOFS_ST_OC;
    assign output_ok_flag = s_reg.pd;

    property p_ov_latch;
        @(posedge clk) disable iff (!rst_n)
        s_reg.st == BOFS_ST_RUN && !clr && ovr_if.qual |=>
        overvoltage_fault && output_ok_flag == BOFS_PD_60 && low_side_drive;
    endproperty
    a_ov_latch: assert property (p_ov_latch) else $error("OV not latched");
    property p_ov_filter;
        @(posedge clk) disable iff (!rst_n)
        $rose(overvoltage_fault) |-> $past(fb_above_ov_rise, 3) && $past(fb_above_ov_rise, 2);
    endproperty
    a_ov_filter: assert property (p_ov_filter) else $error("OV without cause");
    property p_uv_latch;
        @(posedge clk) disable iff (!rst_n)
        $rose(undervoltage_fault) |-> output_ok_flag == BOFS_PD_95 && converter_off;
    endproperty
    a_uv_latch: assert property (p_uv_latch) else $error("UV code wrong");
    property p_uv_filter;
        @(posedge clk) disable iff (!rst_n)
        $rose(undervoltage_fault) |-> $past(fb_below_uv, 2);
    endproperty
    a_uv_filter: assert property (p_uv_filter) else $error("UV without cause");
    property p_hold;
        @(posedge clk) disable iff (!rst_n)
        converter_off && !clr |=> converter_off && $stable(output_ok_flag);
    endproperty
    a_hold: assert property (p_hold) else $error("fault not held");
    property p_clear;
        @(posedge clk) disable iff (!rst_n)
        clr |=> !converter_off && !low_side_drive;
    endproperty
    a_clear: assert property (p_clear) else $error("latch not cleared");
    property p_ls_off;
        @(posedge clk) disable iff (!rst_n)
        overvoltage_fault && !clr && ovf_if.qual && !ovr_if.qual |=> !low_side_drive;
    endproperty
    a_ls_off: assert property (p_ls_off) else $error("low side stuck on");
    property p_ls_on;
        @(posedge clk) disable iff (!rst_n)
        overvoltage_fault && !clr && ovr_if.qual |=> low_side_drive;
    endproperty
    a_ls_on: assert property (p_ls_on) else $error("low side not on");
    property p_ss;
        @(posedge clk) disable iff (!rst_n)
        !converter_off && !clr && soft_start && !ovr_if.qual && !oc_if.qual && !uv_if.qual
        |=> output_ok_flag == BOFS_PD_95;
    endproperty
    a_ss: assert property (p_ss) else $error("soft-start code wrong");
    property p_oc;
        @(posedge clk) disable iff (!rst_n)
        $rose(overcurrent_fault) |-> output_ok_flag == BOFS_PD_30 && $past(current_limit_sense, 8);
    endproperty
    a_oc: assert property (p_oc) else $error("OC code wrong");

    // Same-edge qualification resolves OV first, then OC, then UV
    property p_oc_latch;
        @(posedge clk) disable iff (!rst_n)
        s_reg.st == BOFS_ST_RUN && !clr && !ovr_if.qual && oc_if.qual |=>
        overcurrent_fault && output_ok_flag == BOFS_PD_30;
    endproperty
    a_oc_latch: assert property (p_oc_latch) else $error("OC not latched");

    property p_uv_order;
        @(posedge clk) disable iff (!rst_n)
        s_reg.st == BOFS_ST_RUN && !clr && !ovr_if.qual && !oc_if.qual && uv_if.qual |=>
        undervoltage_fault && output_ok_flag == BOFS_PD_95;
    endproperty
    a_uv_order: assert property (p_uv_order) else $error("UV not latched");

    property p_no_cause;
        @(posedge clk) disable iff (!rst_n)
        s_reg.st == BOFS_ST_RUN && !ovr_if.qual && !oc_if.qual && !uv_if.qual |=>
        !converter_off;
    endproperty
    a_no_cause: assert property (p_no_cause) else $error("fault without filter");

    // Latched state never moves except through a clear
    property p_keep_state;
        @(posedge clk) disable iff (!rst_n)
        converter_off && !clr |=> $stable(s_reg.st);
    endproperty
    a_keep_state: assert property (p_keep_state) else $error("first fault replaced");

    property p_clear_code;
        @(posedge clk) disable iff (!rst_n)
        clr |=> output_ok_flag == BOFS_PD_NONE && !overvoltage_fault &&
        !undervoltage_fault && !overcurrent_fault;
    endproperty
    a_clear_code: assert property (p_clear_code) else $error("code not cleared");

    property p_ss_off;
        @(posedge clk) disable iff (!rst_n)
        !converter_off && !clr && !soft_start && !ovr_if.qual && !oc_if.qual && !uv_if.qual
        |=> output_ok_flag == BOFS_PD_NONE;
    endproperty
    a_ss_off: assert property (p_ss_off) else $error("idle code wrong");

    // Discharge only moves on a qualified crossing, never on a glitch
    property p_ls_hold;
        @(posedge clk) disable iff (!rst_n)
        overvoltage_fault && !clr && !ovr_if.qual && !ovf_if.qual |=> $stable(low_side_drive);
    endproperty
    a_ls_hold: assert property (p_ls_hold) else $error("low side moved unqualified");

    // UV and OC latch with the low side parked off
    property p_ls_only_ov;
        @(posedge clk) disable iff (!rst_n)
        low_side_drive |-> overvoltage_fault;
    endproperty
    a_ls_only_ov: assert property (p_ls_only_ov) else $error("low side outside OV");

    c_ov: cover property (@(posedge clk) disable iff (!rst_n) $rose(overvoltage_fault));
    c_ls_cycle: cover property (@(posedge clk) disable iff (!rst_n)
        overvoltage_fault && $fell(low_side_drive));
    c_uv: cover property (@(posedge clk) disable iff (!rst_n) $rose(undervoltage_fault));
    c_oc: cover property (@(posedge clk) disable iff (!rst_n) $rose(overcurrent_fault));
    c_ss: cover property (@(posedge clk) disable iff (!rst_n)
        soft_start && output_ok_flag == BOFS_PD_95);
endmodule
`default_nettype wire

/* File: verif/bofs_fb_model.sv */
// Feedback comparator model in front of the fault supervisor
`timescale 1ns/1ps
`default_nettype none
module bofs_fb_model (
    // Feedback level, per mille of reference
    input wire logic [11:0] fb_pm,
    // Comparator flags
    output logic above_ov_rise,
    output logic below_ov_fall,
    output logic below_uv
);
    // Ideal comparators, no hysteresis; the device filters do the deglitching
    assign above_ov_rise = (fb_pm > 12'h488);
    assign below_ov_fall = (fb_pm < 12'h424);
    assign below_uv = (fb_pm < 12'h35C);
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the output fault supervisor
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import bofs_pkg::*;
    // Short filters keep the run brief
    localparam int N = 4;
    localparam int NOC = 6;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] fb_pm = 12'h3E8;
    logic cls = 1'b0;
    logic en_low = 1'b0;
    logic por = 1'b0;
    logic ss = 1'b0;
    wire logic ov_r, ov_f, uv_b;
    logic off, ls, ov, uv, oc;
    bofs_pd_t code;
    int n_errors = 0;
    int compares = 0;
    always #4 clk = ~clk;
    bofs_fb_model FB (.fb_pm(fb_pm), .above_ov_rise(ov_r), .below_ov_fall(ov_f),
        .below_uv(uv_b));
    bofs_top #(.OV_CYC(N), .UV_CYC(N), .OC_CYC(NOC), .CNT_W(11)) DUT (
        .clk(clk), .rst_n(rst_n), .fb_above_ov_rise(ov_r), .fb_below_ov_fall(ov_f),
        .fb_below_uv(uv_b), .current_limit_sense(cls), .enable_low(en_low),
        .supply_por(por), .soft_start(ss), .converter_off(off), .low_side_drive(ls),
        .overvoltage_fault(ov), .undervoltage_fault(uv), .overcurrent_fault(oc),
        .output_ok_flag(code));
    // Inputs move 1 ns after the edge, outputs settled by then
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [1:0] got, input logic [1:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic test_start();
        chk({off, ls}, 2'h0);
        chk(code, BOFS_PD_NONE);
        ss = 1'b1;
        cyc(1);
        chk(code, BOFS_PD_95);
        ss = 1'b0;
        cyc(2);
        $display("test_start done");
    endtask
    task automatic test_uv();
        fb_pm = 12'h320;
        cyc(N);
        fb_pm = 12'h3E8;
        cyc(N + 3);
        chk(uv, 1'b0);
        fb_pm = 12'h320;
        cyc(N + 1);
        chk(uv, 1'b0);
        cyc(1);
        chk({uv, off}, 2'h3);
        chk(code, BOFS_PD_95);
        fb_pm = 12'h4B0;
        cyc(N + 3);
        chk({uv, ov}, 2'h2);
        chk(code, BOFS_PD_95);
        fb_pm = 12'h3E8;
        en_low = 1'b1;
        cyc(1);
        chk({uv, off}, 2'h0);
        en_low = 1'b0;
        cyc(1);
        $display("test_uv done");
    endtask
    task automatic test_ov();
        fb_pm = 12'h4B0;
        cyc(N + 1);
        chk(ov, 1'b0);
        cyc(1);
        chk({ov, off}, 2'h3);
        chk(code, BOFS_PD_60);
        chk(ls, 1'b1);
        fb_pm = 12'h3E8;
        cyc(N + 1);
        chk(ls, 1'b1);
        cyc(1);
        chk({ov, ls}, 2'h2);
        fb_pm = 12'h4B0;
        cyc(N + 2);
        chk({ov, ls}, 2'h3);
        fb_pm = 12'h3E8;
        por = 1'b1;
        cyc(1);
        chk({ov, off}, 2'h0);
        por = 1'b0;
        cyc(N + 3);
        chk(ov, 1'b0);
        $display("test_ov done");
    endtask
    task automatic test_oc();
        cls = 1'b1;
        cyc(NOC + 1);
        chk(oc, 1'b0);
        cyc(1);
        chk({oc, off}, 2'h3);
        chk(code, BOFS_PD_30);
        cls = 1'b0;
        en_low = 1'b1;
        cyc(1);
        chk({oc, off}, 2'h0);
        en_low = 1'b0;
        cyc(1);
        $display("test_oc done");
    endtask
    task automatic test_order();
        // OC starts two edges early so OC and UV qualify on the same edge
        cls = 1'b1;
        cyc(2);
        fb_pm = 12'h320;
        cyc(NOC);
        chk({oc, uv}, 2'h2);
        chk(code, BOFS_PD_30);
        cyc(3);
        chk({oc, uv}, 2'h2);
        chk(code, BOFS_PD_30);
        cls = 1'b0;
        fb_pm = 12'h3E8;
        por = 1'b1;
        cyc(1);
        chk({oc, off}, 2'h0);
        chk(code, BOFS_PD_NONE);
        por = 1'b0;
        cyc(1);
        $display("test_order done");
    endtask
    task automatic results();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        cyc(10);
        rst_n = 1'b1;
        cyc(1);
        test_start();
        test_uv();
        test_ov();
        test_oc();
        test_order();
        results();
    end
endmodule
`default_nettype wire
